// ### include/pti_pkg.sv
// Purpose: Shared constants and types of the PCI target pin interface.
// Assumes: 100 MHz core clock, serial memory organised as 16-bit words.
// Notes: Rule summary follows.
package pti_pkg;
	// Bus commands on the command lines during the address phase.
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	// Configuration dword indices held in the header memory.
	localparam logic [5:0] CFG_DW_ID = 6'h00;
	localparam logic [5:0] CFG_DW_CLASS = 6'h02;
	localparam logic [5:0] CFG_DW_SUBSYS = 6'h0B;
	localparam logic [1:0] MEM_ID = 2'h0;
	localparam logic [1:0] MEM_CLASS = 2'h1;
	localparam logic [1:0] MEM_SUBSYS = 2'h2;
	// Serial memory read: start bit and read opcode, then address.
	localparam logic [2:0] EE_READ_OP = 3'h6;
	localparam logic [4:0] EE_CMD_LAST = 5'h08;
	localparam logic [4:0] EE_BIT_LAST = 5'h18;
	localparam logic [2:0] EE_WORD_LAST = 3'h5;
	// Serial clock half period, least time.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS = 500;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [7:0] SCLK_DIV_LAST = 8'(SCLK_HALF_CYC - 1);
	// Target bus states.
	typedef enum logic [4:0] {
		T_IDLE = 5'h01,
		T_DEVSEL = 5'h02,
		T_DATA = 5'h04,
		T_STOPW = 5'h08,
		T_TURN = 5'h10
	} pti_tstate_e;
	// Header loader states.
	typedef enum logic [2:0] {
		L_GAP = 3'h1,
		L_SHIFT = 3'h2,
		L_DONE = 3'h4
	} pti_lstate_e;
endpackage

// ### verilog/pti_hdr_mem.sv
// Purpose: Small header memory with half-word writes and registered read.
// Assumes: Single clock, write and read may happen in the same cycle.
// Notes: Contents are undefined until the loader has written them.
`timescale 1ns/10ps
module pti_hdr_mem #(
	parameter int AW = 2
) (
	input wire logic clk, // Core clock.
	input wire logic we, // Write strobe.
	input wire logic [AW-1:0] waddr, // Write word address.
	input wire logic whalf, // High half when set.
	input wire logic [15:0] wdata, // Half-word to write.
	input wire logic [AW-1:0] raddr, // Read word address.
	output logic [31:0] rdata // Registered read data.
);
	logic [31:0] mem [0:(1<<AW)-1];

	// Writes one half of a word and registers the read word.
	always_ff @(posedge clk) begin
		if (we) begin
			if (whalf) begin
				mem[waddr][31:16] <= wdata;
			end else begin
				mem[waddr][15:0] <= wdata;
			end
		end
		rdata <= mem[raddr];
	end
endmodule // pti_hdr_mem

// ### verilog/pti_target.sv
// Purpose: PCI target pins, single-phase transfers, header loader.
// Assumes: Bus pins are synchronous to clk; user answers reads at once.
// Notes: Tri-state pins appear as value, input and active-low enable.
`timescale 1ns/10ps
module pti_target #(
	parameter logic [31:0] BAR_BASE = 32'h0001_0000,
	parameter logic [31:0] BAR_MASK = 32'hFFFF_FF00
) (
	input wire logic clk, // Bus clock.
	input wire logic rst, // Bus reset, active high, asynchronous.
	input wire logic [31:0] ad_in, // Address/data pins in.
	output logic [31:0] ad_out, // Address/data pins out.
	output logic ad_oe_n, // Address/data enable, low drives.
	input wire logic [3:0] cbe_n_in, // Command/byte enable pins.
	input wire logic par_in, // Parity pin in.
	output logic par_out, // Parity pin out.
	output logic par_oe_n, // Parity enable, low drives.
	input wire logic frame_n_in, // Cycle frame.
	input wire logic irdy_n_in, // Initiator ready.
	input wire logic idsel, // Configuration select.
	output logic devsel_n_out, // Device select out.
	output logic trdy_n_out, // Target ready out.
	output logic stop_n_out, // Stop out.
	output logic ctl_oe_n, // Enable of the three controls above.
	input wire logic irq_req, // Interrupt request level.
	output logic inta_out, // Interrupt pin value.
	output logic inta_oe_n, // Interrupt enable, low pulls low.
	input wire logic pme_req, // Power event request level.
	output logic pme_out, // Power event pin value.
	output logic pme_oe_n, // Power event enable, low pulls low.
	output logic mem_cs, // Serial memory chip select.
	output logic memory_serial_clock, // Serial memory clock.
	output logic memory_serial_in, // Data toward the memory.
	input wire logic memory_serial_out, // Data from the memory.
	output logic cfg_loaded, // Header load finished.
	output logic [31:0] usr_addr, // Decoded access address.
	output logic [3:0] usr_cmd, // Decoded access command.
	output logic usr_rd, // Read request pulse.
	input wire logic [31:0] usr_rdata, // Read data, valid with usr_rd.
	output logic usr_wr, // Write pulse.
	output logic [31:0] usr_wdata, // Write data.
	output logic [3:0] usr_be_n // Write byte enables, active low.
);
	pti_pkg::pti_tstate_e tstate_reg, tstate_next;
	pti_pkg::pti_lstate_e lstate_reg, lstate_next;
	logic frame_q_reg, frame_q_next, cfg_reg, cfg_next, retry_reg, retry_next;
	logic [31:0] addr_reg, addr_next, ad_out_reg, ad_out_next;
	logic [3:0] cmd_reg, cmd_next, be_reg, be_next;
	logic ad_oe_reg, ad_oe_next, par_reg, par_next, par_oe_reg, par_oe_next;
	logic devsel_reg, devsel_next, trdy_reg, trdy_next, stop_reg, stop_next;
	logic ctl_oe_reg, ctl_oe_next, rd_reg, rd_next, wr_reg, wr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [7:0] div_reg, div_next;
	logic [4:0] bit_reg, bit_next;
	logic [2:0] word_reg, word_next;
	logic [15:0] shift_reg, shift_next;
	logic sclk_reg, sclk_next, cs_reg, cs_next, sout_reg, sout_next;
	logic loaded_reg, loaded_next, do_meta_reg, do_sync_reg;
	logic start, is_cfg, is_bar, hit, tick, mem_we;
	logic [2:0] slot_in, slot_q;
	logic [31:0] mem_rdata;
	logic [8:0] ee_cmd;

	// Maps a configuration dword index to {valid, memory word}.
	function automatic logic [2:0] cfg_slot(input logic [5:0] dw);
		if (dw == pti_pkg::CFG_DW_ID) begin
			cfg_slot = {1'b1, pti_pkg::MEM_ID};
		end else if (dw == pti_pkg::CFG_DW_CLASS) begin
			cfg_slot = {1'b1, pti_pkg::MEM_CLASS};
		end else if (dw == pti_pkg::CFG_DW_SUBSYS) begin
			cfg_slot = {1'b1, pti_pkg::MEM_SUBSYS};
		end else begin
			cfg_slot = 3'h0;
		end
	endfunction

	// Address phase decode of configuration and window accesses.
	assign start = frame_q_reg && !frame_n_in && (tstate_reg == pti_pkg::T_IDLE);
	assign is_cfg = idsel && (ad_in[1:0] == 2'h0) &&
		(cbe_n_in == pti_pkg::CMD_CFG_RD || cbe_n_in == pti_pkg::CMD_CFG_WR);
	assign is_bar = ((ad_in & BAR_MASK) == BAR_BASE) &&
		(cbe_n_in == pti_pkg::CMD_IO_RD || cbe_n_in == pti_pkg::CMD_IO_WR ||
		cbe_n_in == pti_pkg::CMD_MEM_RD || cbe_n_in == pti_pkg::CMD_MEM_WR);
	assign hit = is_cfg || is_bar;
	assign slot_in = cfg_slot(ad_in[7:2]);
	assign slot_q = cfg_slot(addr_reg[7:2]);

	// Next values of the bus target.
	always_comb begin
		tstate_next = tstate_reg;
		frame_q_next = frame_n_in;
		addr_next = addr_reg;
		cmd_next = cmd_reg;
		cfg_next = cfg_reg;
		retry_next = retry_reg;
		ad_out_next = ad_out_reg;
		ad_oe_next = 1'b1;
		par_next = ^{ad_out_reg, cbe_n_in};
		par_oe_next = ad_oe_reg;
		devsel_next = 1'b1;
		trdy_next = 1'b1;
		stop_next = 1'b1;
		ctl_oe_next = 1'b1;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		be_next = be_reg;
		case (tstate_reg)
			pti_pkg::T_IDLE: begin
				if (start && hit) begin
					addr_next = ad_in;
					cmd_next = cbe_n_in;
					cfg_next = is_cfg;
					retry_next = !loaded_reg;
					rd_next = is_bar && !cbe_n_in[0] && loaded_reg;
					devsel_next = 1'b0;
					ctl_oe_next = 1'b0;
					tstate_next = pti_pkg::T_DEVSEL;
				end
			end
			pti_pkg::T_DEVSEL: begin
				devsel_next = 1'b0;
				ctl_oe_next = 1'b0;
				if (cfg_reg) begin
					ad_out_next = slot_q[2] ? mem_rdata : 32'h0000_0000;
				end else begin
					ad_out_next = usr_rdata;
				end
				if (retry_reg) begin
					stop_next = 1'b0;
					tstate_next = pti_pkg::T_STOPW;
				end else begin
					trdy_next = 1'b0;
					stop_next = frame_n_in;
					ad_oe_next = cmd_reg[0];
					tstate_next = pti_pkg::T_DATA;
				end
			end
			pti_pkg::T_DATA: begin
				devsel_next = 1'b0;
				ctl_oe_next = 1'b0;
				if (!irdy_n_in) begin
					wr_next = cmd_reg[0] && !cfg_reg;
					wdata_next = ad_in;
					be_next = cbe_n_in;
					if (!frame_n_in) begin
						stop_next = 1'b0;
						tstate_next = pti_pkg::T_STOPW;
					end else begin
						tstate_next = pti_pkg::T_TURN;
					end
				end else begin
					trdy_next = 1'b0;
					stop_next = frame_n_in;
					ad_oe_next = cmd_reg[0];
				end
			end
			pti_pkg::T_STOPW: begin
				ctl_oe_next = 1'b0;
				if (frame_n_in) begin
					tstate_next = pti_pkg::T_TURN;
				end else begin
					devsel_next = 1'b0;
					stop_next = 1'b0;
				end
			end
			default: begin
				tstate_next = pti_pkg::T_IDLE;
			end
		endcase
	end

	// Registers of the bus target, all timed from the bus clock.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tstate_reg <= pti_pkg::T_IDLE;
			frame_q_reg <= 1'b1;
			addr_reg <= 32'h0000_0000;
			cmd_reg <= 4'h0;
			cfg_reg <= 1'b0;
			retry_reg <= 1'b0;
			ad_out_reg <= 32'h0000_0000;
			ad_oe_reg <= 1'b1;
			par_reg <= 1'b0;
			par_oe_reg <= 1'b1;
			devsel_reg <= 1'b1;
			trdy_reg <= 1'b1;
			stop_reg <= 1'b1;
			ctl_oe_reg <= 1'b1;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			be_reg <= 4'hF;
		end else begin
			tstate_reg <= tstate_next;
			frame_q_reg <= frame_q_next;
			addr_reg <= addr_next;
			cmd_reg <= cmd_next;
			cfg_reg <= cfg_next;
			retry_reg <= retry_next;
			ad_out_reg <= ad_out_next;
			ad_oe_reg <= ad_oe_next;
			par_reg <= par_next;
			par_oe_reg <= par_oe_next;
			devsel_reg <= devsel_next;
			trdy_reg <= trdy_next;
			stop_reg <= stop_next;
			ctl_oe_reg <= ctl_oe_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			be_reg <= be_next;
		end
	end

	// Serial memory read command for the current word.
	assign ee_cmd = {pti_pkg::EE_READ_OP, 3'h0, word_reg};
	assign tick = (div_reg == pti_pkg::SCLK_DIV_LAST);
	assign mem_we = (lstate_reg == pti_pkg::L_SHIFT) && tick && sclk_reg &&
		(bit_reg == pti_pkg::EE_BIT_LAST);

	// Next values of the header loader.
	always_comb begin
		lstate_next = lstate_reg;
		div_next = tick ? 8'h00 : div_reg + 8'h01;
		bit_next = bit_reg;
		word_next = word_reg;
		shift_next = shift_reg;
		sclk_next = sclk_reg;
		cs_next = cs_reg;
		sout_next = sout_reg;
		loaded_next = loaded_reg;
		case (lstate_reg)
			pti_pkg::L_GAP: begin
				if (tick) begin
					cs_next = 1'b1;
					bit_next = 5'h00;
					sout_next = ee_cmd[8];
					lstate_next = pti_pkg::L_SHIFT;
				end
			end
			pti_pkg::L_SHIFT: begin
				if (tick && !sclk_reg) begin
					sclk_next = 1'b1;
				end else if (tick) begin
					sclk_next = 1'b0;
					if (bit_reg > pti_pkg::EE_CMD_LAST) begin
						shift_next = {shift_reg[14:0], do_sync_reg};
					end
					if (bit_reg == pti_pkg::EE_BIT_LAST) begin
						cs_next = 1'b0;
						sout_next = 1'b0;
						word_next = word_reg + 3'h1;
						if (word_reg == pti_pkg::EE_WORD_LAST) begin
							lstate_next = pti_pkg::L_DONE;
						end else begin
							lstate_next = pti_pkg::L_GAP;
						end
					end else begin
						bit_next = bit_reg + 5'h01;
						sout_next = (bit_reg < pti_pkg::EE_CMD_LAST) ?
							ee_cmd[3'(pti_pkg::EE_CMD_LAST - bit_reg - 5'h01)] :
							1'b0;
					end
				end
			end
			default: begin
				div_next = 8'h00;
				sclk_next = 1'b0;
				cs_next = 1'b0;
				loaded_next = 1'b1;
			end
		endcase
	end

	// Registers of the loader; returned data passes two flip-flops.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lstate_reg <= pti_pkg::L_GAP;
			div_reg <= 8'h00;
			bit_reg <= 5'h00;
			word_reg <= 3'h0;
			shift_reg <= 16'h0000;
			sclk_reg <= 1'b0;
			cs_reg <= 1'b0;
			sout_reg <= 1'b0;
			loaded_reg <= 1'b0;
			do_meta_reg <= 1'b0;
			do_sync_reg <= 1'b0;
		end else begin
			lstate_reg <= lstate_next;
			div_reg <= div_next;
			bit_reg <= bit_next;
			word_reg <= word_next;
			shift_reg <= shift_next;
			sclk_reg <= sclk_next;
			cs_reg <= cs_next;
			sout_reg <= sout_next;
			loaded_reg <= loaded_next;
			do_meta_reg <= memory_serial_out;
			do_sync_reg <= do_meta_reg;
		end
	end

	// Header words: even serial word fills the low half of a dword.
	pti_hdr_mem #(.AW(2)) pti_hdr_mem_i (
		.clk(clk),
		.we(mem_we),
		.waddr(word_reg[2:1]),
		.whalf(word_reg[0]),
		.wdata({shift_reg[14:0], do_sync_reg}),
		.raddr(slot_in[1:0]),
		.rdata(mem_rdata)
	);

	// Pin and user outputs; open-drain lines follow the request levels.
	assign inta_out = 1'b0;
	assign inta_oe_n = !irq_req;
	assign pme_out = 1'b0;
	assign pme_oe_n = !pme_req;
	assign ad_out = ad_out_reg;
	assign ad_oe_n = ad_oe_reg;
	assign par_out = par_reg;
	assign par_oe_n = par_oe_reg;
	assign devsel_n_out = devsel_reg;
	assign trdy_n_out = trdy_reg;
	assign stop_n_out = stop_reg;
	assign ctl_oe_n = ctl_oe_reg;
	assign mem_cs = cs_reg;
	assign memory_serial_clock = sclk_reg;
	assign memory_serial_in = sout_reg;
	assign cfg_loaded = loaded_reg;
	assign usr_addr = addr_reg;
	assign usr_cmd = cmd_reg;
	assign usr_rd = rd_reg;
	assign usr_wr = wr_reg;
	assign usr_wdata = wdata_reg;
	assign usr_be_n = be_reg;

	// Checks of pin behaviour.
	sequence s_hit;
		start && hit && loaded_reg;
	endsequence
	property p_inta;
		@(posedge clk) disable iff (rst) irq_req |-> !inta_oe_n && !inta_out;
	endproperty
	a_inta: assert property (p_inta) else $error("int not pulled");
	property p_pme;
		@(posedge clk) disable iff (rst) !pme_req |-> pme_oe_n;
	endproperty
	a_pme: assert property (p_pme) else $error("pme not released");
	property p_claim;
		@(posedge clk) disable iff (rst)
		s_hit |=> !devsel_n_out ##1 (!devsel_n_out && !trdy_n_out);
	endproperty
	a_claim: assert property (p_claim) else $error("no claim");
	property p_burst;
		@(posedge clk) disable iff (rst)
		tstate_reg == pti_pkg::T_DATA && !irdy_n_in && !frame_n_in |=>
			!stop_n_out && trdy_n_out;
	endproperty
	a_burst: assert property (p_burst) else $error("burst not stopped");
	property p_par;
		@(posedge clk) disable iff (rst)
		!ad_oe_n |=> par_out == ^{$past(ad_out), $past(cbe_n_in)} && !par_oe_n;
	endproperty
	a_par: assert property (p_par) else $error("bad parity");
	property p_idle;
		@(posedge clk) disable iff (rst) !mem_cs |-> !memory_serial_clock;
	endproperty
	a_idle: assert property (p_idle) else $error("clock while idle");
	property p_retry;
		@(posedge clk) disable iff (rst)
		start && hit && !loaded_reg |=> ##1 !stop_n_out && trdy_n_out;
	endproperty
	a_retry: assert property (p_retry) else $error("no retry");
	property p_sout;
		@(posedge clk) disable iff (rst)
		memory_serial_clock && $past(memory_serial_clock) |->
			$stable(memory_serial_in);
	endproperty
	a_sout: assert property (p_sout) else $error("data moved");
	property p_sample;
		@(posedge clk) disable iff (rst)
		lstate_reg == pti_pkg::L_SHIFT && tick && sclk_reg &&
		bit_reg > pti_pkg::EE_CMD_LAST && bit_reg < pti_pkg::EE_BIT_LAST |=>
			shift_reg[0] == $past(do_sync_reg);
	endproperty
	a_sample: assert property (p_sample) else $error("bit lost");
	property p_reset;
		@(posedge clk) rst |-> ctl_oe_n && ad_oe_n && !mem_cs;
	endproperty
	a_reset: assert property (p_reset) else $error("drive in reset");
endmodule // pti_target

// ### tb/pti_mem_model.sv
// Purpose: Serial header memory model that answers read commands.
// Assumes: Word n holds 5A00 plus n; a command is start, read, address.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/10ps
module pti_mem_model (
	input wire logic cs, // Chip select, active high.
	input wire logic sclk, // Serial clock.
	input wire logic din, // Data toward the memory.
	output logic dout, // Data from the memory.
	output int n_words, // Read commands taken.
	output int n_bad // Commands out of form or order.
);
	logic [8:0] cmd;
	logic [15:0] word;
	int bitn;
	// The model starts idle with its line parked high.
	initial begin
		dout = 1'b1;
		n_words = 0;
		n_bad = 0;
		bitn = 0;
	end
	// A new select restarts the count; a release floats the line.
	always @(posedge cs) bitn = 0;
	always @(negedge cs) dout = ~dout;
	// Command bits shift in, then data bits shift out.
	always @(posedge sclk) begin
		if (cs) begin
			if (bitn < 9) begin
				cmd = {cmd[7:0], din};
			end else if (bitn < 25) begin
				dout = word[24 - bitn];
			end
			if (bitn == 8) begin
				word = 16'h5A00 | 16'(cmd[5:0]);
				dout = 1'b0;
				if (cmd[8:6] != 3'h6 || cmd[5:0] != 6'(n_words)) n_bad++;
				n_words++;
			end
			bitn++;
		end
	end
endmodule // pti_mem_model

// ### tb/tb_pti_target.sv
// Purpose: Self-checking bench of the PCI target pins and header loader.
// Assumes: The bench plays the bus master; a model plays the memory.
// Notes: Bus signals change at falling edges and are read there too.
`timescale 1ns/10ps
module tb_pti_target;
	logic clk = 0, rst = 0, frame_n = 1, irdy_n = 1, idsel = 0;
	logic [31:0] m_ad = 0, usr_rdata = 0, ad_out, usr_addr, usr_wdata;
	logic [31:0] wr_seen, rd_addr, rd;
	logic [3:0] cbe_n = 4'hF, usr_cmd, usr_be_n, be_seen, cmd_seen;
	logic irq_req = 0, pme_req = 0, ad_oe_n, par_out, par_oe_n;
	logic sclk_bad = 0;
	logic devsel_n_out, trdy_n_out, stop_n_out, ctl_oe_n, inta_out, inta_oe_n;
	logic pme_out, pme_oe_n, mem_cs, sclk, sdi, sdo, cfg_loaded;
	logic usr_rd, usr_wr;
	logic [1:0] resp;
	int n_mismatch = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0;
	int n_words, n_bad;
	// Shared pins: the design wins while its enable is low.
	wire logic [31:0] ad_in = ad_oe_n ? m_ad : ad_out;
	wire logic par_in = par_oe_n ? ~par_out : par_out;
	pti_target pti_target_i (.clk(clk), .rst(rst), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe_n(ad_oe_n), .cbe_n_in(cbe_n),
		.par_in(par_in), .par_out(par_out), .par_oe_n(par_oe_n),
		.frame_n_in(frame_n), .irdy_n_in(irdy_n), .idsel(idsel),
		.devsel_n_out(devsel_n_out), .trdy_n_out(trdy_n_out),
		.stop_n_out(stop_n_out), .ctl_oe_n(ctl_oe_n), .irq_req(irq_req),
		.inta_out(inta_out), .inta_oe_n(inta_oe_n), .pme_req(pme_req),
		.pme_out(pme_out), .pme_oe_n(pme_oe_n), .mem_cs(mem_cs),
		.memory_serial_clock(sclk), .memory_serial_in(sdi),
		.memory_serial_out(sdo), .cfg_loaded(cfg_loaded),
		.usr_addr(usr_addr), .usr_cmd(usr_cmd), .usr_rd(usr_rd),
		.usr_rdata(usr_rdata), .usr_wr(usr_wr), .usr_wdata(usr_wdata),
		.usr_be_n(usr_be_n));
	pti_mem_model pti_mem_model_i (.cs(mem_cs), .sclk(sclk), .din(sdi),
		.dout(sdo), .n_words(n_words), .n_bad(n_bad));
	// The clock runs at 100 MHz.
	always #5 clk = ~clk;
	// User strobes are counted, and a moving idle serial clock is noted.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (usr_wr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_seen <= usr_wdata;
			be_seen <= usr_be_n;
			cmd_seen <= usr_cmd;
		end
		if (usr_rd === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
			rd_addr <= usr_addr;
			cmd_seen <= usr_cmd;
		end
		if (!rst && mem_cs === 1'b0 && sclk !== 1'b0) sclk_bad <= 1'b1;
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			stop_test;
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Compares one value with its expectation.
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One master transaction; resp holds stop and ready as seen.
	task automatic bus(logic [3:0] cmd, logic [31:0] addr, logic [31:0] wd,
		logic [3:0] be, logic cfg, logic burst);
		logic p;
		@(negedge clk);
		frame_n <= 1'b0;
		m_ad <= addr;
		cbe_n <= cmd;
		idsel <= cfg;
		@(negedge clk);
		frame_n <= ~burst;
		irdy_n <= 1'b0;
		cbe_n <= be;
		idsel <= 1'b0;
		m_ad <= cmd[0] ? wd : ~addr;
		resp = 2'h0;
		for (int i = 0; i < 8 && resp == 2'h0; i++) begin
			@(negedge clk);
			if (ctl_oe_n === 1'b0 && (trdy_n_out === 1'b0 ||
				stop_n_out === 1'b0)) begin
				resp = {~stop_n_out, ~trdy_n_out};
				check("devsel", devsel_n_out, 1'b0);
				rd = ad_out;
				p = ^{ad_in, be};
			end
		end
		@(negedge clk);
		if (resp[0] && !cmd[0]) check("parity", par_out, p);
		if (resp[0] && !cmd[0]) check("par_oe_n", par_oe_n, 1'b0);
		frame_n <= 1'b1;
		if (burst) @(negedge clk);
		irdy_n <= 1'b1;
		m_ad <= ~m_ad;
		cbe_n <= 4'hF;
		repeat (3) @(negedge clk);
	endtask
	// Reset values, then a retry while the header is still loading.
	task automatic t_early;
		check("ctl_oe_n", ctl_oe_n, 1'b1);
		check("ad_oe_n", ad_oe_n, 1'b1);
		check("loaded", cfg_loaded, 1'b0);
		bus(pti_pkg::CMD_CFG_RD, 32'h0, 32'h0, 4'h0, 1'b1, 1'b0);
		check("retry", resp, 2'h2);
	endtask
	// The loader reads six words in order and idles its clock.
	task automatic t_load;
		for (int i = 0; i < 20000 && cfg_loaded !== 1'b1; i++) @(negedge clk);
		check("loaded", cfg_loaded, 1'b1);
		check("words", n_words, 6);
		check("bad_cmd", n_bad, 0);
		check("sclk_idle", sclk_bad, 1'b0);
		check("cs_idle", mem_cs, 1'b0);
	endtask
	// Header dwords read back as loaded; writes leave them unchanged.
	task automatic t_cfg;
		logic [5:0] dw[4] = '{6'h00, 6'h02, 6'h0B, 6'h01};
		logic [31:0] ex[4] = '{32'h5A01_5A00, 32'h5A03_5A02,
			32'h5A05_5A04, 32'h0};
		bus(pti_pkg::CMD_CFG_WR, 32'h0, 32'h1234_5678, 4'h0, 1'b1, 1'b0);
		check("cfg_wr", resp, 2'h1);
		for (int i = 0; i < 4; i++) begin
			bus(pti_pkg::CMD_CFG_RD, {24'h0, dw[i], 2'h0}, 32'h0, 4'h0,
				1'b1, 1'b0);
			check("cfg_resp", resp, 2'h1);
			check("cfg_data", rd, ex[i]);
		end
	endtask
	// Each user command once, then a burst and a missed address.
	task automatic t_user;
		logic [3:0] c[4] = '{pti_pkg::CMD_IO_RD, pti_pkg::CMD_IO_WR,
			pti_pkg::CMD_MEM_RD, pti_pkg::CMD_MEM_WR};
		int w;
		for (int i = 0; i < 4; i++) begin
			usr_rdata = 32'hC0DE_0000 + i;
			w = wr_cnt;
			bus(c[i], 32'h0001_0010 + 4 * i, 32'hA5A5_0000 + i, 4'h5 - i,
				1'b0, 1'b0);
			check("resp", resp, 2'h1);
			check("usr_cmd", cmd_seen, c[i]);
			if (c[i][0]) begin
				check("wr_cnt", wr_cnt, w + 1);
				check("wdata", wr_seen, 32'hA5A5_0000 + i);
				check("be_n", be_seen, 4'h5 - i);
			end else begin
				check("rdata", rd, 32'hC0DE_0000 + i);
				check("rd_addr", rd_addr, 32'h0001_0010 + 4 * i);
			end
		end
		w = wr_cnt;
		bus(pti_pkg::CMD_MEM_WR, 32'h0001_0020, 32'h0F0F_0F0F, 4'h0,
			1'b0, 1'b1);
		check("burst_resp", resp, 2'h3);
		check("burst_wr", wr_cnt, w + 1);
		bus(pti_pkg::CMD_MEM_WR, 32'h0002_0000, 32'h0, 4'h0, 1'b0, 1'b0);
		check("miss_resp", resp, 2'h0);
		check("miss_wr", wr_cnt, w + 1);
	endtask
	// Event lines and reset act between clock edges.
	task automatic t_async;
		@(negedge clk);
		#2 irq_req = 1'b1;
		pme_req = 1'b1;
		#1 check("inta_oe_n", inta_oe_n, 1'b0);
		check("inta_out", inta_out, 1'b0);
		check("pme_oe_n", pme_oe_n, 1'b0);
		check("pme_out", pme_out, 1'b0);
		irq_req = 1'b0;
		pme_req = 1'b0;
		#1 check("inta_rel", inta_oe_n, 1'b1);
		check("pme_rel", pme_oe_n, 1'b1);
		rst = 1'b1;
		#1 check("rst_loaded", cfg_loaded, 1'b0);
		check("rst_ctl", ctl_oe_n, 1'b1);
	endtask
	// Main sequence: reset for three cycles, then each scenario.
	initial begin
		// Raised after time zero so that the asynchronous reset sees an edge.
		#1 rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_early;
		t_load;
		t_cfg;
		t_user;
		t_async;
		stop_test;
	end
endmodule // tb_pti_target
